// file: core/dtc_top.sv
// Chosen here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "dtc_consts.svh"
module dtc_top
  import dtc_pkg::*;
(
  input wire logic SYS_CLK_IN,
  input wire logic RSTN_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  input wire logic EVENT_INPUT_A_IN,
  input wire logic EVENT_INPUT_B_IN,
  output logic TIMER_OUT_A_OUT,
  output logic TIMER_OUT_B_OUT,
  output logic IRQ_MATCH_A_OUT,
  output logic IRQ_MATCH_B_OUT
);
  dtc_state_type st_reg;
  dtc_state_type st_next;
  dtc_tick_if tk_a ();
  dtc_tick_if tk_b ();
  logic addr_phase;
  logic [7:0] addr_lo;
  logic tick_a;
  logic tick_b;
  logic match_a;
  logic match_b;
  logic match_16;
  logic [31:0] rd_mux;
  logic [7:0] wbyte;

  // Prescaler runs free so the first tick after start is not aligned
  assign tk_a.sel = st_reg.clksel[3:0];
  assign tk_a.div = st_reg.div;
  assign tk_a.evt = EVENT_INPUT_A_IN;
  assign tk_b.sel = st_reg.clksel[7:4];
  assign tk_b.div = st_reg.div;
  assign tk_b.evt = EVENT_INPUT_B_IN;

  dtc_clksel u_sel_a (
    .clk_in(SYS_CLK_IN),
    .rstn_in(RSTN_IN),
    .tk(tk_a.gen)
  );

  dtc_clksel u_sel_b (
    .clk_in(SYS_CLK_IN),
    .rstn_in(RSTN_IN),
    .tk(tk_b.gen)
  );

  assign tick_a = tk_a.tick;
  assign tick_b = tk_b.tick;
  assign addr_phase = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
  assign addr_lo = HADDR_IN[7:0];
  assign wbyte = HWDATA_IN[7:0];
  assign match_a = (st_reg.cnt_a == st_reg.cmp_a);
  assign match_b = (st_reg.cnt_b == st_reg.cmp_b);
  assign match_16 = match_a & match_b;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (addr_lo)
      `DTC_OFF_CLKSEL: rd_mux = {24'h00_0000, st_reg.clksel};
      `DTC_OFF_MODE: begin
        rd_mux[`DTC_MODE_CE_A] = st_reg.ce_a;
        rd_mux[`DTC_MODE_CE_B] = st_reg.ce_b;
        rd_mux[`DTC_MODE_CASCADE] = st_reg.cascade;
      end
      `DTC_OFF_OUTCTL: begin
        // Level bits are write-only strobes and read as zero
        rd_mux[`DTC_OC_OE_A] = st_reg.oe_a;
        rd_mux[`DTC_OC_OE_B] = st_reg.oe_b;
      end
      `DTC_OFF_CMP_A: rd_mux = {24'h00_0000, st_reg.cmp_a};
      `DTC_OFF_CMP_B: rd_mux = {24'h00_0000, st_reg.cmp_b};
      // Both bytes from one sample so a carry cannot tear the value
      `DTC_OFF_COUNT: rd_mux = {16'h0000, st_reg.cnt_b, st_reg.cnt_a};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    st_next.div = st_reg.div + 12'h001;
    st_next.irq_a = 1'b0;
    st_next.irq_b = 1'b0;
    st_next.hready = 1'b1;

    if (st_reg.cascade) begin
      if (tick_a && st_reg.ce_a) begin
        if (match_a) begin
          st_next.irq_a = 1'b1;
          if (st_reg.oe_a) begin
            st_next.out_a = ~st_reg.out_a;
          end
        end
        if (match_16) begin
          // Clear on the tick after the match gives (N + 1) clocks
          st_next.cnt_a = 8'h00;
          st_next.cnt_b = 8'h00;
          st_next.irq_b = 1'b1;
          if (st_reg.oe_b) begin
            st_next.out_b = ~st_reg.out_b;
          end
        end else begin
          st_next.cnt_a = st_reg.cnt_a + 8'h01;
          if (st_reg.cnt_a == 8'hff) begin
            st_next.cnt_b = st_reg.cnt_b + 8'h01;
          end
        end
      end
    end else begin
      if (tick_a && st_reg.ce_a) begin
        if (match_a) begin
          st_next.cnt_a = 8'h00;
          st_next.irq_a = 1'b1;
          if (st_reg.oe_a) begin
            st_next.out_a = ~st_reg.out_a;
          end
        end else begin
          st_next.cnt_a = st_reg.cnt_a + 8'h01;
        end
      end
      if (tick_b && st_reg.ce_b) begin
        if (match_b) begin
          st_next.cnt_b = 8'h00;
          st_next.irq_b = 1'b1;
          if (st_reg.oe_b) begin
            st_next.out_b = ~st_reg.out_b;
          end
        end else begin
          st_next.cnt_b = st_reg.cnt_b + 8'h01;
        end
      end
    end

    // Bus write lands in the data phase, after counting, so software wins
    if (st_reg.wr_pend) begin
      case (st_reg.wr_addr)
        `DTC_OFF_CLKSEL: st_next.clksel = wbyte;
        `DTC_OFF_MODE: begin
          st_next.ce_a = wbyte[`DTC_MODE_CE_A];
          st_next.ce_b = wbyte[`DTC_MODE_CE_B];
          st_next.cascade = wbyte[`DTC_MODE_CASCADE];
          // Stopped counters restart from zero
          if (!wbyte[`DTC_MODE_CE_A]) begin
            st_next.cnt_a = 8'h00;
          end
          if (!wbyte[`DTC_MODE_CE_B] && !wbyte[`DTC_MODE_CASCADE]) begin
            st_next.cnt_b = 8'h00;
          end
          if (!wbyte[`DTC_MODE_CE_A] && wbyte[`DTC_MODE_CASCADE]) begin
            st_next.cnt_b = 8'h00;
          end
        end
        `DTC_OFF_OUTCTL: begin
          st_next.oe_a = wbyte[`DTC_OC_OE_A];
          st_next.oe_b = wbyte[`DTC_OC_OE_B];
          // Set takes priority if both level bits are written at once
          if (wbyte[`DTC_OC_LVR_A]) begin
            st_next.out_a = 1'b0;
          end
          if (wbyte[`DTC_OC_LVS_A]) begin
            st_next.out_a = 1'b1;
          end
          if (wbyte[`DTC_OC_LVR_B]) begin
            st_next.out_b = 1'b0;
          end
          if (wbyte[`DTC_OC_LVS_B]) begin
            st_next.out_b = 1'b1;
          end
        end
        `DTC_OFF_CMP_A: st_next.cmp_a = wbyte;
        `DTC_OFF_CMP_B: st_next.cmp_b = wbyte;
        default: st_next.cmp_a = st_next.cmp_a;
      endcase
    end

    st_next.wr_pend = addr_phase & HWRITE_IN;
    st_next.wr_addr = addr_lo;
    if (addr_phase && !HWRITE_IN) begin
      st_next.hrdata = rd_mux;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      st_reg <= '0;
      st_reg.hready <= 1'b1;
      st_reg.oe_a <= 1'b0;
      st_reg.clksel <= `DTC_RST_BYTE;
    end else begin
      st_reg <= st_next;
    end
  end

  assign HRDATA_OUT = st_reg.hrdata;
  assign HREADYOUT_OUT = st_reg.hready;
  assign HRESP_OUT = 1'b0;
  assign TIMER_OUT_A_OUT = st_reg.out_a;
  assign TIMER_OUT_B_OUT = st_reg.out_b;
  assign IRQ_MATCH_A_OUT = st_reg.irq_a;
  assign IRQ_MATCH_B_OUT = st_reg.irq_b;
endmodule : dtc_top
`default_nettype wire

// file: core/dtc_consts.svh
// Functional notes
// - 8-bit mode: match toggles channel output when its enable bit is set.
// - Channel A count clock picked by select bits 0..3, main clock /2../4096.
// - Software sets channel A output start level via reset/set bits 2, 3.
// - Mode control bit 2 set joins both channels into one 16-bit counter.
// - 16-bit mode: low uses channel A clock, high counts low overflows.
// - 16-bit mode: count-enable bit 0 alone runs or halts counting.
// - 16-bit interval: full match clears both, keeps counting, raises B request.
// - 16-bit mode: low match still raises A request and toggles A output.
// - 16-bit event mode: low counts pin edges, overflow advances high.
// - Event pin valid edge selectable rising or falling.
// - 16-bit event mode: full match clears both counters, raises B request.
// - Select codes 0000, 0001 count pin edges; unlisted codes give no clock.
// - 16-bit square wave: B output toggles on full match, gated by enable bit 4.
// - 8-bit mode: each channel match clears counter, raises request, counts on.
// - Reset clears the output control register to zero.
// - First match after start may come up to one count clock early.
`ifndef DTC_CONSTS_SVH
`define DTC_CONSTS_SVH
`define DTC_OFF_CLKSEL 8'h00
`define DTC_OFF_MODE 8'h04
`define DTC_OFF_OUTCTL 8'h08
`define DTC_OFF_CMP_A 8'h0c
`define DTC_OFF_CMP_B 8'h10
`define DTC_OFF_COUNT 8'h14
`define DTC_MODE_CE_A 0
`define DTC_MODE_CE_B 1
`define DTC_MODE_CASCADE 2
`define DTC_OC_OE_A 0
`define DTC_OC_LVR_A 2
`define DTC_OC_LVS_A 3
`define DTC_OC_OE_B 4
`define DTC_OC_LVR_B 5
`define DTC_OC_LVS_B 6
`define DTC_RST_BYTE 8'h00
`define DTC_SEL_EDGE_FALL 4'h0
`define DTC_SEL_EDGE_RISE 4'h1
`define DTC_SEL_DIV2 4'h5
`define DTC_SEL_DIV4 4'h6
`define DTC_SEL_DIV8 4'h7
`define DTC_SEL_DIV16 4'h8
`define DTC_SEL_DIV32 4'h9
`define DTC_SEL_DIV64 4'ha
`define DTC_SEL_DIV128 4'hb
`define DTC_SEL_DIV256 4'hc
`define DTC_SEL_DIV512 4'hd
`define DTC_SEL_DIV1024 4'he
`define DTC_SEL_DIV4096 4'hf
`endif

// file: core/dtc_pkg.sv
package dtc_pkg;
  typedef struct packed {
    logic [11:0] div;
    logic [7:0] cnt_a;
    logic [7:0] cnt_b;
    logic [7:0] cmp_a;
    logic [7:0] cmp_b;
    logic [7:0] clksel;
    logic ce_a;
    logic ce_b;
    logic cascade;
    logic oe_a;
    logic oe_b;
    logic out_a;
    logic out_b;
    logic irq_a;
    logic irq_b;
    logic [31:0] hrdata;
    logic hready;
    logic wr_pend;
    logic [7:0] wr_addr;
  } dtc_state_type;

  typedef struct packed {
    logic evt_prev;
  } dtc_sel_state_type;
endpackage : dtc_pkg

// file: core/dtc_tick_if.sv
`timescale 1ns/100ps
`default_nettype none
interface dtc_tick_if;
  logic [3:0] sel;
  logic [11:0] div;
  logic evt;
  logic tick;
  modport core (output sel, output div, output evt, input tick);
  modport gen (input sel, input div, input evt, output tick);
endinterface : dtc_tick_if
`default_nettype wire

// file: core/dtc_clksel.sv
`timescale 1ns/100ps
`default_nettype none
`include "dtc_consts.svh"
module dtc_clksel
  import dtc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  dtc_tick_if.gen tk
);
  dtc_sel_state_type st_reg;
  dtc_sel_state_type st_next;

  always_comb begin
    st_next = st_reg;
    st_next.evt_prev = tk.evt;
    tk.tick = 1'b0;
    case (tk.sel)
      `DTC_SEL_EDGE_FALL: tk.tick = st_reg.evt_prev & ~tk.evt;
      `DTC_SEL_EDGE_RISE: tk.tick = ~st_reg.evt_prev & tk.evt;
      `DTC_SEL_DIV2: tk.tick = tk.div[0];
      `DTC_SEL_DIV4: tk.tick = &tk.div[1:0];
      `DTC_SEL_DIV8: tk.tick = &tk.div[2:0];
      `DTC_SEL_DIV16: tk.tick = &tk.div[3:0];
      `DTC_SEL_DIV32: tk.tick = &tk.div[4:0];
      `DTC_SEL_DIV64: tk.tick = &tk.div[5:0];
      `DTC_SEL_DIV128: tk.tick = &tk.div[6:0];
      `DTC_SEL_DIV256: tk.tick = &tk.div[7:0];
      `DTC_SEL_DIV512: tk.tick = &tk.div[8:0];
      `DTC_SEL_DIV1024: tk.tick = &tk.div[9:0];
      `DTC_SEL_DIV4096: tk.tick = &tk.div[11:0];
      // Prohibited codes stop the count clock
      default: tk.tick = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : dtc_clksel
`default_nettype wire

// file: dv/dtc_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module dtc_assertions (
  input wire logic SYS_CLK_IN,
  input wire logic RSTN_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic HREADY_IN,
  input wire logic [31:0] HRDATA_OUT,
  input wire logic HREADYOUT_OUT,
  input wire logic HRESP_OUT,
  input wire logic TIMER_OUT_A_OUT,
  input wire logic IRQ_MATCH_A_OUT,
  input wire logic IRQ_MATCH_B_OUT
);
  default clocking @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!RSTN_IN);
  logic rd;
  logic [7:0] a;
  assign rd = HSEL_IN && HTRANS_IN[1] && HREADY_IN && !HWRITE_IN;
  assign a = HADDR_IN[7:0];
  AST_OK: assert property (HREADYOUT_OUT && !HRESP_OUT) else $error("bus stall or error");
  AST_RST: assert property ($rose(RSTN_IN) |-> !TIMER_OUT_A_OUT && !IRQ_MATCH_B_OUT)
    else $error("output set after reset");
  AST_IRQ_A: assert property (IRQ_MATCH_A_OUT |=> !IRQ_MATCH_A_OUT)
    else $error("match a pulse too long");
  AST_IRQ_B: assert property (IRQ_MATCH_B_OUT |=> !IRQ_MATCH_B_OUT)
    else $error("match b pulse too long");
  AST_UNMAP: assert property (rd && a > 8'h17 |=> HRDATA_OUT == 0) else $error("unmapped read");
  AST_LEVEL: assert property (rd && a == 8'h08 |=> (HRDATA_OUT & 32'hffff_ffee) == 0)
    else $error("level bits read back");
  AST_COUNT: assert property (rd && a == 8'h14 |=> HRDATA_OUT[31:16] == 0)
    else $error("count above 16 bits");
  AST_HOLD: assert property (!rd |=> $stable(HRDATA_OUT)) else $error("read data moved");
endmodule : dtc_assertions
bind dtc_top dtc_assertions u_chk (.SYS_CLK_IN, .RSTN_IN, .HSEL_IN, .HADDR_IN, .HTRANS_IN,
  .HWRITE_IN, .HREADY_IN, .HRDATA_OUT, .HREADYOUT_OUT, .HRESP_OUT, .TIMER_OUT_A_OUT,
  .IRQ_MATCH_A_OUT, .IRQ_MATCH_B_OUT);
`default_nettype wire

// file: dv/dtc_event_src.sv
`timescale 1ns/100ps
`default_nettype none
module dtc_event_src (
  input wire logic clk_in,
  output logic evt_out
);
  // Always driven, so the pin never floats
  initial evt_out = 1'b0;
  task automatic level(logic v);
    repeat (2) @(posedge clk_in);
    evt_out <= v;
  endtask : level
  task automatic pulses(int n);
    repeat (n) begin
      level(1);
      level(0);
    end
  endtask : pulses
endmodule : dtc_event_src
`default_nettype wire

// file: dv/test_dual_timer_cascade_square_wave.sv
`timescale 1ns/100ps
`default_nettype none
module test_dual_timer_cascade_square_wave;
  logic clk = 0, rstn = 0, hsel = 0, hwr = 0, evt, evt_b, rdy, resp, oa, ob, ia, ib;
  logic [1:0] htr = 0;
  logic [2:0] hsz = 0;
  logic [31:0] ha = 0, hwd = 0, hrd, rdata;
  int n_errors = 0, tests_run = 0, na = 0, nb = 0, cyc = 0, a0, a1, b0, b1;
  dtc_top u_dut (.SYS_CLK_IN(clk), .RSTN_IN(rstn), .HSEL_IN(hsel), .HADDR_IN(ha),
    .HTRANS_IN(htr), .HWRITE_IN(hwr), .HSIZE_IN(hsz), .HWDATA_IN(hwd), .HREADY_IN(rdy),
    .HRDATA_OUT(hrd), .HREADYOUT_OUT(rdy), .HRESP_OUT(resp), .EVENT_INPUT_A_IN(evt),
    .EVENT_INPUT_B_IN(evt_b), .TIMER_OUT_A_OUT(oa), .TIMER_OUT_B_OUT(ob),
    .IRQ_MATCH_A_OUT(ia), .IRQ_MATCH_B_OUT(ib));
  dtc_event_src u_src (.clk_in(clk), .evt_out(evt));
  dtc_event_src u_src_b (.clk_in(clk), .evt_out(evt_b));
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (ia === 1) {na, a0, a1} <= {na + 1, a1, cyc};
    if (ib === 1) {nb, b0, b1} <= {nb + 1, b1, cyc};
  end
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic bus(logic w, logic [7:0] ad, logic [7:0] d);
    hsel <= 1;
    htr <= 2'b10;
    hwr <= w;
    hsz <= 3'b010;
    ha <= {24'h0, ad};
    do @(posedge clk); while (rdy !== 1);
    htr <= 0;
    hwd <= {24'h0, d};
    do @(posedge clk); while (rdy !== 1);
    rdata = hrd;
  endtask : bus
  task automatic end_of_test();
    if (n_errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  task automatic t_regs();
    bus(0, 8'h08, 0);
    chk("oc", 0, rdata);
    chk("resp", 0, resp);
    bus(0, 8'h40, 0);
    chk("unmap", 0, rdata);
    bus(1, 8'h08, 8'h08);
    bus(0, 8'h08, 0);
    chk("lvs", 1, oa);
    chk("lvrd", 0, rdata);
    bus(1, 8'h08, 8'h04);
    bus(0, 8'h08, 0);
    chk("lvr", 0, oa);
  endtask : t_regs
  task automatic t_8bit();
    int k;
    bus(1, 8'h0c, 0);
    for (int c = 15; c > 4; c--) begin
      bus(1, 8'h04, 0);
      bus(1, 8'h00, c[7:0]);
      bus(1, 8'h04, 1);
      k = na + 2;
      repeat (9000) if (na < k) @(posedge clk);
      chk("div", c == 15 ? 4096 : 1 << (c - 4), a1 - a0);
    end
    chk("oe_off", 0, oa);
    bus(1, 8'h04, 0);
    bus(1, 8'h0c, 3);
    bus(1, 8'h08, 8'h05);
    k = na;
    bus(1, 8'h04, 1);
    repeat (60) @(posedge clk);
    bus(1, 8'h04, 0);
    repeat (4) @(posedge clk);
    chk("per", 8, a1 - a0);
    chk("sq", (na - k) & 1, oa);
  endtask : t_8bit
  task automatic t_16();
    int k, j;
    bus(1, 8'h08, 8'h35);
    bus(1, 8'h0c, 1);
    bus(1, 8'h10, 1);
    j = na;
    k = nb;
    // Low match requests stay unmasked so they can be counted
    bus(1, 8'h04, 8'h05);
    repeat (1200) if (nb < k + 2) @(posedge clk);
    bus(1, 8'h04, 8'h04);
    repeat (4) @(posedge clk);
    chk("p16", 516, b1 - b0);
    chk("sqb", (nb - k) & 1, ob);
    chk("sqa", (na - j) & 1, oa);
    chk("lo", 1, na > j + 1);
    bus(0, 8'h14, 0);
    chk("halt", 0, rdata);
  endtask : t_16
  task automatic t_evt();
    int k;
    bus(1, 8'h00, 1);
    bus(1, 8'h0c, 2);
    bus(1, 8'h04, 5);
    k = nb;
    u_src.pulses(258);
    bus(0, 8'h14, 0);
    chk("ev", 32'h0102, rdata);
    u_src.pulses(1);
    repeat (4) @(posedge clk);
    chk("evi", k + 1, nb);
    bus(0, 8'h14, 0);
    chk("evc", 0, rdata);
  endtask : t_evt
  task automatic t_fall();
    int k;
    bus(1, 8'h04, 0);
    bus(1, 8'h0c, 0);
    bus(1, 8'h00, 0);
    bus(1, 8'h04, 1);
    k = na;
    u_src.level(1);
    repeat (4) @(posedge clk);
    chk("rise", k, na);
    u_src.level(0);
    repeat (4) @(posedge clk);
    chk("fall", k + 1, na);
    bus(1, 8'h00, 2);
    u_src.pulses(2);
    repeat (4) @(posedge clk);
    chk("bad", k + 1, na);
  endtask : t_fall
  task automatic t_b();
    int k;
    bus(1, 8'h04, 0);
    bus(1, 8'h10, 1);
    bus(1, 8'h08, 8'h30);
    bus(1, 8'h00, 8'h10);
    bus(1, 8'h04, 8'h02);
    k = nb;
    u_src_b.pulses(3);
    repeat (4) @(posedge clk);
    chk("b8", k + 1, nb);
    chk("tob", 1, ob);
    bus(0, 8'h14, 0);
    chk("cntb", 32'h0100, rdata);
  endtask : t_b
  task automatic t_rst();
    bus(1, 8'h08, 8'h19);
    rstn <= 0;
    repeat (2) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    chk("rsto", 0, oa);
    bus(0, 8'h08, 0);
    chk("rstoc", 0, rdata);
  endtask : t_rst
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    t_regs();
    t_8bit();
    t_16();
    t_evt();
    t_fall();
    t_b();
    t_rst();
    end_of_test();
  end
  // Longest divider alone needs about 8200 cycles
  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    end_of_test();
  end
endmodule : test_dual_timer_cascade_square_wave
`default_nettype wire
